// ==== core/icc_pkg.sv ====
// Package: constants, register map and types of the common interrupt clear block
package icc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int ICC_NGRP = 4;   // Number of event groups
  localparam int ICC_GW   = 8;   // Bits per group register
  localparam int ICC_AW   = 16;  // APB address width
  localparam int ICC_DW   = 32;  // APB data width

  // Group indices
  localparam int ICC_GRP_SYSTEM_CLOCK_DOMAIN = 0;
  localparam int ICC_GRP_AUX    = 1;
  localparam int ICC_GRP_REF_GROUP_A_EVENT_CLEAR   = 2;
  localparam int ICC_GRP_REF_GROUP_B_EVENT_CLEAR   = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [ICC_NGRP-1:0][ICC_AW-1:0] ICC_IDX_CLR  =
    {16'h2009, 16'h2008, 16'h2007, 16'h2006};
  localparam logic [ICC_NGRP-1:0][ICC_AW-1:0] ICC_IDX_STAT =
    {16'h3009, 16'h3008, 16'h3007, 16'h3006};
  localparam logic [ICC_NGRP-1:0][ICC_AW-1:0] ICC_IDX_MASK =
    {16'h3109, 16'h3108, 16'h3107, 16'h3106};
  localparam logic [1:0] ICC_ADDR_SHIFT = 2'h2;

  // Bits that latch an event in each group; others are reserved and read zero
  localparam logic [ICC_NGRP-1:0][ICC_GW-1:0] ICC_IMPL =
    {8'hFF, 8'hFF, 8'h3F, 8'h0F};
  localparam logic [ICC_GW-1:0] ICC_RST_VAL = 8'h00;

  // System clock group fields
  localparam int ICC_SYS_CAL_START = 3;
  localparam int ICC_SYS_WDOG      = 2;
  localparam int ICC_SYS_NVM_FAULT = 1;
  localparam int ICC_SYS_NVM_DONE  = 0;
  // Compensation loop group fields
  localparam int ICC_AUX_SKEW      = 5;
  localparam int ICC_AUX_TEMP      = 4;
  localparam int ICC_AUX_UNFAULT   = 3;
  localparam int ICC_AUX_FAULT     = 2;
  localparam int ICC_AUX_UNLOCK    = 1;
  localparam int ICC_AUX_LOCK      = 0;
  // Reference groups: complement input in upper nibble, true input in lower
  localparam int ICC_REF_RESYNC    = 3;
  localparam int ICC_REF_VALID     = 2;
  localparam int ICC_REF_UNFAULT   = 1;
  localparam int ICC_REF_FAULT     = 0;
  localparam int ICC_REF_CMP_OFS   = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef logic [ICC_NGRP-1:0][ICC_GW-1:0] icc_grp_t;

  // Event pulses; system_clock_domain lands at group index 0
  typedef struct packed {
    logic [ICC_GW-1:0] ref_group_b_event_clear;
    logic [ICC_GW-1:0] ref_group_a_event_clear;
    logic [ICC_GW-1:0] aux;
    logic [ICC_GW-1:0] system_clock_domain;
  } icc_evt_s;

  typedef enum logic [1:0] {
    ICC_KIND_NONE,
    ICC_KIND_CLR,
    ICC_KIND_STAT,
    ICC_KIND_MASK
  } icc_kind_e;

  typedef struct packed {
    icc_kind_e           kind;
    logic [ICC_NGRP-1:0] sel;
  } icc_dec_s;

  typedef struct packed {
    icc_grp_t            latched;
    icc_grp_t            mask;
    logic [ICC_DW-1:0]   rdata;
    logic                err;
    logic [ICC_NGRP-1:0] rd_stat;
    logic                irq;
  } icc_state_s;

endpackage

// ==== core/icc_irq_clear.sv ====
// Latched common interrupts with write-one-to-clear, mask and APB slave
//
// Functional notes
// - Writing 1 to system clock clear bit 3 clears calibration-started event.
// - Writing 1 to system clock clear bit 2 clears watchdog timeout event.
// - Writing 1 to system clock clear bit 1 clears memory fault event.
// - Writing 1 to system clock clear bit 0 clears memory done event.
// - Writing 1 to loop clear bit 5 clears skew limit exceeded event.
// - Writing 1 to loop clear bit 4 clears temperature warning event.
// - Writing 1 to loop clear bit 3 clears compensation loop unfaulted.
// - Writing 1 to loop clear bit 2 clears compensation loop faulted.
// - Writing 1 to loop clear bit 1 clears compensation loop unlocked.
// - Writing 1 to loop clear bit 0 clears compensation loop locked.
// - Group A clear bits 7..4 clear complement input A events.
// - Group A clear bits 3..0 clear input A events.
// - Group B clear bits 7..4 clear complement input B events.
// - Group B clear bits 3..0 clear input B events.
// - Each input B clear bit acts alone; other latched events stay.
module icc_irq_clear
  import icc_pkg::*;
(
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [icc_pkg::ICC_AW-1:0] paddr,
  input  wire logic [icc_pkg::ICC_DW-1:0] pwdata,
  output logic                       pready,
  output logic [icc_pkg::ICC_DW-1:0] prdata,
  output logic                       pslverr,
  // Event pulses from the detectors, same clock
  input  wire icc_pkg::icc_evt_s     evt,
  // Interrupt and latched state
  output logic                       irq,
  output icc_pkg::icc_grp_t          latched
);
  import icc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode, used for the read capture and for the access write
  function automatic icc_dec_s icc_decode(input logic [ICC_AW-1:0] addr);
    icc_dec_s d;
    d.kind = ICC_KIND_NONE;
    d.sel  = '0;
    for (int g = 0; g < ICC_NGRP; g++) begin
      if (addr == (ICC_IDX_CLR[g] << ICC_ADDR_SHIFT)) begin
        d.kind = ICC_KIND_CLR;
        d.sel[g] = 1'b1;
      end
      if (addr == (ICC_IDX_STAT[g] << ICC_ADDR_SHIFT)) begin
        d.kind = ICC_KIND_STAT;
        d.sel[g] = 1'b1;
      end
      if (addr == (ICC_IDX_MASK[g] << ICC_ADDR_SHIFT)) begin
        d.kind = ICC_KIND_MASK;
        d.sel[g] = 1'b1;
      end
    end
    return d;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State
  icc_state_s s;
  icc_state_s next_s;
  icc_grp_t   evt_grp;
  icc_dec_s   dec;
  logic       setup_ph;
  logic       access_ph;

  assign evt_grp   = icc_grp_t'(evt);
  assign dec       = icc_decode(paddr);
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    icc_grp_t wr_clr;
    icc_grp_t rd_clr;
    logic [ICC_GW-1:0] rd_val;
    wr_clr = '0;
    rd_clr = '0;
    rd_val = '0;
    next_s = s;
    // Read data captured in setup so prdata comes from a flip-flop
    if (setup_ph) begin
      for (int g = 0; g < ICC_NGRP; g++) begin
        if (dec.sel[g] && dec.kind == ICC_KIND_STAT) begin
          rd_val = s.latched[g];
        end
        if (dec.sel[g] && dec.kind == ICC_KIND_MASK) begin
          rd_val = s.mask[g];
        end
      end
      // Clear registers read back as zero
      next_s.rdata   = {{(ICC_DW-ICC_GW){1'b0}}, rd_val};
      next_s.err     = (dec.kind == ICC_KIND_NONE);
      next_s.rd_stat = (dec.kind == ICC_KIND_STAT && !pwrite) ? dec.sel : '0;
    end
    for (int g = 0; g < ICC_NGRP; g++) begin
      // Only ones in the written byte clear; zeros leave bits alone
      if (access_ph && pwrite && dec.kind == ICC_KIND_CLR && dec.sel[g]) begin
        wr_clr[g] = pwdata[ICC_GW-1:0];
      end
      // Read-to-clear drops only the captured bits, so an event that
      // lands between setup and access is not lost unseen
      if (access_ph && !pwrite && s.rd_stat[g]) begin
        rd_clr[g] = s.rdata[ICC_GW-1:0];
      end
      // Event set wins over any clear in the same cycle
      next_s.latched[g] = ((s.latched[g] & ~(wr_clr[g] | rd_clr[g])) | evt_grp[g])
                          & ICC_IMPL[g];
      if (access_ph && pwrite && dec.kind == ICC_KIND_MASK && dec.sel[g]) begin
        next_s.mask[g] = pwdata[ICC_GW-1:0] & ICC_IMPL[g];
      end
    end
    // Access retires any pending read-to-clear capture
    if (access_ph) begin
      next_s.rd_stat = '0;
    end
    // Registered level interrupt, high while any unmasked bit is latched
    next_s.irq = |(next_s.latched & next_s.mask);
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs; zero wait states since read data is ready after setup
  assign pready  = 1'b1;
  assign prdata  = s.rdata;
  assign pslverr = access_ph & s.err;
  assign irq     = s.irq;
  assign latched = s.latched;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [ICC_NGRP-1:0] wr_clr_reg;
  always_comb begin
    for (int g = 0; g < ICC_NGRP; g++) begin
      wr_clr_reg[g] = access_ph && pwrite && paddr == (ICC_IDX_CLR[g] << ICC_ADDR_SHIFT);
    end
  end

  a_sys_cal_start: assert property (
    wr_clr_reg[0] && pwdata[3] && !evt.system_clock_domain[3] |=> !latched[0][3])
    else $error("calibration start event not cleared");
  a_sys_wdog: assert property (
    wr_clr_reg[0] && pwdata[2] && !evt.system_clock_domain[2] |=> !latched[0][2])
    else $error("watchdog event not cleared");
  a_sys_nvm_fault: assert property (
    wr_clr_reg[0] && pwdata[1] && !evt.system_clock_domain[1] |=> !latched[0][1])
    else $error("memory fault event not cleared");
  a_sys_nvm_done: assert property (
    wr_clr_reg[0] && pwdata[0] && !evt.system_clock_domain[0] |=> !latched[0][0])
    else $error("memory done event not cleared");
  a_aux_skew: assert property (
    wr_clr_reg[1] && pwdata[5] && !evt.aux[5] |=> !latched[1][5])
    else $error("skew event not cleared");
  a_aux_temp: assert property (
    wr_clr_reg[1] && pwdata[4] && !evt.aux[4] |=> !latched[1][4])
    else $error("temperature event not cleared");
  a_aux_unfault: assert property (
    wr_clr_reg[1] && pwdata[3] && !evt.aux[3] |=> !latched[1][3])
    else $error("loop unfaulted event not cleared");
  a_aux_fault: assert property (
    wr_clr_reg[1] && pwdata[2] && !evt.aux[2] |=> !latched[1][2])
    else $error("loop faulted event not cleared");
  a_aux_unlock: assert property (
    wr_clr_reg[1] && pwdata[1] && !evt.aux[1] |=> !latched[1][1])
    else $error("loop unlocked event not cleared");
  a_aux_lock: assert property (
    wr_clr_reg[1] && pwdata[0] && !evt.aux[0] |=> !latched[1][0])
    else $error("loop locked event not cleared");
  a_ref_group_a_event_clear_cmp_clear: assert property (
    wr_clr_reg[2] && pwdata[7:4] == 4'hF && evt.ref_group_a_event_clear[7:4] == 4'h0
    |=> latched[2][7:4] == 4'h0)
    else $error("complement input A events not cleared");
  a_ref_group_a_event_clear_true_clear: assert property (
    wr_clr_reg[2] && pwdata[3:0] == 4'hF && evt.ref_group_a_event_clear[3:0] == 4'h0
    |=> latched[2][3:0] == 4'h0)
    else $error("input A events not cleared");
  a_ref_group_b_event_clear_cmp_clear: assert property (
    wr_clr_reg[3] && pwdata[7:4] == 4'hF && evt.ref_group_b_event_clear[7:4] == 4'h0
    |=> latched[3][7:4] == 4'h0)
    else $error("complement input B events not cleared");
  a_ref_group_b_event_clear_true_clear: assert property (
    wr_clr_reg[3] && pwdata[3:0] == 4'hF && evt.ref_group_b_event_clear[3:0] == 4'h0
    |=> latched[3][3:0] == 4'h0)
    else $error("input B events not cleared");
  a_ref_group_b_event_clear_bit_alone: assert property (
    wr_clr_reg[3] && pwdata[1:0] == 2'h2 && latched[3][0] && !evt.ref_group_b_event_clear[1]
    |=> latched[3][0] && !latched[3][1])
    else $error("input B clear disturbed another event");
  a_zero_write_keeps: assert property (
    wr_clr_reg[1] && pwdata[7:0] == 8'h00
    |=> latched[1] == (($past(latched[1]) | $past(evt.aux)) & ICC_IMPL[1]))
    else $error("zero write changed latched events");
  a_set_beats_clear: assert property (
    wr_clr_reg[2] && pwdata[0] && evt.ref_group_a_event_clear[0] |=> latched[2][0] [*2])
    else $error("event lost against simultaneous clear");
  a_latched_holds: assert property (
    latched[0][2] && !wr_clr_reg[0] && !s.rd_stat[0] |=> latched[0][2])
    else $error("latched event dropped without a clear");
  a_irq_follows: assert property (
    (|(latched & s.mask)) |-> irq)
    else $error("interrupt low while unmasked event latched");

  //////////////////////////////////////////////////////////////////////////////
  // Per-group address hits, taken from the shared decoder so the checks
  // and the logic cannot disagree about the map
  logic [ICC_NGRP-1:0] clr_hit;
  logic [ICC_NGRP-1:0] stat_hit;
  logic [ICC_NGRP-1:0] mask_hit;

  assign clr_hit  = (dec.kind == ICC_KIND_CLR)  ? dec.sel : '0;
  assign stat_hit = (dec.kind == ICC_KIND_STAT) ? dec.sel : '0;
  assign mask_hit = (dec.kind == ICC_KIND_MASK) ? dec.sel : '0;

  //////////////////////////////////////////////////////////////////////////////
  // Bus-level checks

  // Zero wait states: every access completes at its first edge
  a_pready_high: assert property (
    pready)
    else $error("pready low");

  // Error response only in an access, never in setup or idle
  a_slverr_access: assert property (
    pslverr |-> access_ph)
    else $error("pslverr outside an access");

  // Unmapped places answer with an error
  a_slverr_unmapped: assert property (
    access_ph && dec.kind == ICC_KIND_NONE |-> pslverr)
    else $error("unmapped access without error");

  // Mapped places never answer with an error
  a_mapped_clean: assert property (
    access_ph && dec.kind != ICC_KIND_NONE |-> !pslverr)
    else $error("mapped access flagged as error");

  // Only the low byte carries data; the rest reads zero
  a_rdata_upper: assert property (
    prdata[ICC_DW-1:ICC_GW] == '0)
    else $error("upper read data bits not zero");

  // Read data moves only after a setup edge, so it stands through access
  a_rdata_stands: assert property (
    !setup_ph |=> prdata == $past(prdata))
    else $error("read data changed outside setup");

  // Clear registers hold no state and read back zero
  a_clear_reads_zero: assert property (
    access_ph && !pwrite && (|clr_hit) |-> prdata == '0)
    else $error("clear register read back nonzero");

  // Interrupt low whenever nothing unmasked is latched
  a_irq_low_idle: assert property (
    !(|(latched & s.mask)) |-> !irq)
    else $error("interrupt high with no unmasked event");

  // Latched bits fall only at an access edge; idle and setup keep them
  a_drop_needs_access: assert property (
    !access_ph |=> (($past(latched) & ~latched) == '0))
    else $error("latched event dropped outside an access");

  // A pending read-to-clear capture is retired by its access
  a_rd_stat_retire: assert property (
    access_ph |=> s.rd_stat == '0)
    else $error("read-to-clear capture left pending");

  // Input B fault clear leaves the unfaulted event latched
  a_ref_group_b_event_clear_fault_alone: assert property (
    wr_clr_reg[ICC_GRP_REF_GROUP_B_EVENT_CLEAR] && pwdata[ICC_GW-1:0] == 8'h01
    && latched[ICC_GRP_REF_GROUP_B_EVENT_CLEAR][ICC_REF_UNFAULT] && !evt.ref_group_b_event_clear[ICC_REF_FAULT]
    |=> latched[ICC_GRP_REF_GROUP_B_EVENT_CLEAR][ICC_REF_UNFAULT] && !latched[ICC_GRP_REF_GROUP_B_EVENT_CLEAR][ICC_REF_FAULT])
    else $error("input B fault clear disturbed unfaulted event");

  // Complement input B fault clear leaves its unfaulted event latched
  a_refbc_fault_alone: assert property (
    wr_clr_reg[ICC_GRP_REF_GROUP_B_EVENT_CLEAR] && pwdata[ICC_GW-1:0] == 8'h10
    && latched[ICC_GRP_REF_GROUP_B_EVENT_CLEAR][ICC_REF_CMP_OFS+ICC_REF_UNFAULT]
    && !evt.ref_group_b_event_clear[ICC_REF_CMP_OFS+ICC_REF_FAULT]
    |=> latched[ICC_GRP_REF_GROUP_B_EVENT_CLEAR][ICC_REF_CMP_OFS+ICC_REF_UNFAULT]
    && !latched[ICC_GRP_REF_GROUP_B_EVENT_CLEAR][ICC_REF_CMP_OFS+ICC_REF_FAULT])
    else $error("complement B fault clear disturbed unfaulted event");

  //////////////////////////////////////////////////////////////////////////////
  // Per-group register checks
  for (genvar g = 0; g < ICC_NGRP; g++) begin : g_grp_chk

    // A clear write drops exactly the written ones; events still win
    a_clear_exact: assert property (
      access_ph && pwrite && clr_hit[g]
      |=> latched[g] == ((($past(latched[g]) & ~$past(pwdata[ICC_GW-1:0]))
                         | $past(evt_grp[g])) & ICC_IMPL[g]))
      else $error("clear write gave wrong latched byte");

    // Clearing one group never touches another
    a_other_keep: assert property (
      access_ph && pwrite && (|clr_hit) && !clr_hit[g]
      |=> latched[g] == (($past(latched[g]) | $past(evt_grp[g])) & ICC_IMPL[g]))
      else $error("clear write disturbed another group");

    // Status registers are read-only; writes leave them alone
    a_stat_write_ignored: assert property (
      access_ph && pwrite && stat_hit[g]
      |=> latched[g] == (($past(latched[g]) | $past(evt_grp[g])) & ICC_IMPL[g]))
      else $error("status write changed latched events");

    // Status read returns the byte latched at the setup edge
    a_stat_read_data: assert property (
      access_ph && !pwrite && stat_hit[g] |-> prdata[ICC_GW-1:0] == $past(latched[g]))
      else $error("status read returned wrong byte");

    // Status read clears returned ones unless the same bit fires again
    a_stat_read_clear: assert property (
      access_ph && !pwrite && stat_hit[g]
      |=> (latched[g] & $past(prdata[ICC_GW-1:0]) & ~$past(evt_grp[g])) == '0)
      else $error("status read did not clear returned events");

    // Mask write lands at the access edge, reserved bits dropped
    a_mask_write: assert property (
      access_ph && pwrite && mask_hit[g]
      |=> s.mask[g] == ($past(pwdata[ICC_GW-1:0]) & ICC_IMPL[g]))
      else $error("mask write did not land");

    // Mask holds unless its own register is written
    a_mask_hold: assert property (
      !(access_ph && pwrite && mask_hit[g]) |=> s.mask[g] == $past(s.mask[g]))
      else $error("mask changed without a write");

    // Mask read returns the stored mask
    a_mask_read: assert property (
      access_ph && !pwrite && mask_hit[g] |-> prdata[ICC_GW-1:0] == s.mask[g])
      else $error("mask read returned wrong byte");

    // Implemented bits latch their event; reserved bits stay quiet
    for (genvar b = 0; b < ICC_GW; b++) begin : g_bit_chk
      if (ICC_IMPL[g][b]) begin : g_impl
        a_evt_sets: assert property (
          evt_grp[g][b] |=> latched[g][b])
          else $error("event did not latch");
        a_evt_irq: assert property (
          evt_grp[g][b] && s.mask[g][b] && !(access_ph && pwrite && mask_hit[g]) |=> irq)
          else $error("unmasked event raised no interrupt");
      end else begin : g_rsvd
        a_rsvd_quiet: assert property (
          !latched[g][b] && !s.mask[g][b])
          else $error("reserved bit latched or masked");
      end
    end
  end

endmodule

// ==== sim/test_icc_irq_clear.sv ====
// Self-checking bench for the common interrupt clear block
module test_icc_irq_clear
  import icc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic [ICC_AW-1:0] paddr;
  logic [ICC_DW-1:0] pwdata;
  logic [ICC_DW-1:0] prdata;
  icc_evt_s          evt;
  icc_grp_t          latched;
  icc_grp_t          exp_l;
  icc_grp_t          exp_m;
  int                err_count;
  int                comparisons;
  int                seed;

  icc_irq_clear uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .evt(evt), .irq(irq), .latched(latched));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 100 ns period
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Expected latched bits: clear first, a same-cycle event wins
  function automatic icc_grp_t nxt(icc_grp_t o, icc_grp_t c, icc_grp_t e);
    return (o & ~c) | (e & ICC_IMPL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // One APB transfer; the event pattern rides on the access edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input icc_grp_t ev, output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    evt     <= icc_evt_s'(ev);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    evt     <= '0;
  endtask

  // Kinds: 0 clear write, 1 mask write, 2 status read, 3 mask read, 4 clear read
  task automatic op(input int k, input int g, input logic [31:0] d, input icc_grp_t ev);
    logic [15:0] idx;
    logic [31:0] rd;
    logic        er;
    icc_grp_t    c;
    idx = (k == 0 || k == 4) ? ICC_IDX_CLR[g] : (k == 2) ? ICC_IDX_STAT[g] : ICC_IDX_MASK[g];
    c = '0;
    if (k == 0) c[g] = d[7:0];
    if (k == 2) c[g] = exp_l[g];
    apb(k < 2, 16'(idx << ICC_ADDR_SHIFT), d, ev, rd, er);
    check("pslverr", 32'(er), 32'h0);
    if (k == 2) check("status", rd, 32'(exp_l[g]));
    if (k == 3) check("mask", rd, 32'(exp_m[g]));
    if (k == 4) check("clear readback", rd, 32'h0);
    exp_l = nxt(exp_l, c, ev);
    if (k == 1) exp_m[g] = d[7:0];
    // Let the access edge land before looking
    @(negedge pclk);
    check("latched", latched, exp_l);
    check("irq", 32'(irq), 32'(|(exp_l & exp_m)));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] rd;
    logic        er;
    logic [31:0] d;
    int          k;
    int          g;
    seed = 32'hACB3;
    err_count = 0;
    comparisons = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    evt = '0;
    exp_l = '0;
    exp_m = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values of every register
    for (int i = 0; i < ICC_NGRP; i++) begin
      op(3, i, 32'h0, '0);
      op(4, i, 32'h0, '0);
      op(2, i, 32'h0, '0);
    end
    // Unmapped place: error, reads zero, no effect
    apb(1'b1, 16'h0104, 32'hFF, '0, rd, er);
    check("unmapped err", 32'(er), 32'h1);
    apb(1'b0, 16'h0100, 32'h0, '0, rd, er);
    check("unmapped data", rd, 32'h0);
    check("unmapped read err", 32'(er), 32'h1);
    // Status writes are ignored and raise no error
    op(0, ICC_GRP_AUX, 32'h0, '1);
    apb(1'b1, 16'(ICC_IDX_STAT[ICC_GRP_AUX] << ICC_ADDR_SHIFT), 32'hFF, '0, rd, er);
    check("status write err", 32'(er), 32'h0);
    @(negedge pclk);
    check("status write kept", latched, exp_l);
    // Each clear bit alone, every other latched bit kept
    for (int i = 0; i < ICC_NGRP; i++) begin
      for (int b = 0; b < ICC_GW; b++) begin
        op(0, i, 32'h0, '1);
        op(0, i, 32'(8'h01 << b), '0);
      end
    end
    // Clear and event on the same edge: event stays
    op(0, ICC_GRP_REF_GROUP_B_EVENT_CLEAR, 32'hFF, '1);
    // Unmask all, then clear everything: interrupt must drop
    for (int i = 0; i < ICC_NGRP; i++) begin
      op(1, i, 32'(ICC_IMPL[i]), '0);
      op(0, i, 32'hFF, '0);
    end
    // Random mix of clears, masks and reads with sparse events
    repeat (300) begin
      k = $unsigned($random(seed)) % 5;
      g = $unsigned($random(seed)) % ICC_NGRP;
      d = $random(seed);
      if (k == 1) d = d & 32'(ICC_IMPL[g]);
      op(k, g, d, $random(seed) & $random(seed) & $random(seed));
    end
    // Reset in mid-run wipes latched state and masks
    op(0, 0, 32'h0, '1);
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    check("reset latched", latched, 32'h0);
    check("reset irq", 32'(irq), 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    exp_l = '0;
    exp_m = '0;
    op(3, ICC_GRP_AUX, 32'h0, '0);
    give_verdict();
  end

  // Hang guard
  initial begin
    #(100 * 60000);
    err_count++;
    give_verdict();
  end
endmodule
